// ===== hdl/sadc_pkg.sv
package sadc_pkg;
	// Conversion clock select codes
	typedef enum logic [1:0] {
		SADC_DIV8 = 2'b00,
		SADC_DIV16 = 2'b01,
		SADC_DIV32 = 2'b10,
		SADC_DIV128 = 2'b11
	} sadc_clksel_t;
	// Controller states
	typedef enum logic [1:0] {
		SADC_IDLE = 2'b00,
		SADC_CONV = 2'b01,
		SADC_HOLDOFF = 2'b10
	} sadc_state_t;
	localparam int SADC_RES_W = 12;
	localparam logic [4:0] SADC_CH_REF12 = 5'h12;
	localparam logic [4:0] SADC_CH_MAX_PIN = 5'h11;
	localparam logic [5:0] SADC_CONV_PERIODS = 6'h31;
	localparam logic [5:0] SADC_FIRST_BIT_PERIOD = 6'h25;
	localparam logic [1:0] SADC_ABORT_PERIODS = 2'h2;
	localparam logic [7:0] SADC_DIV8_TC = 8'h07;
	localparam logic [7:0] SADC_DIV16_TC = 8'h0F;
	localparam logic [7:0] SADC_DIV32_TC = 8'h1F;
	localparam logic [7:0] SADC_DIV128_TC = 8'h7F;
	localparam logic [7:0] SADC_RESULT_RST = 8'h00;
endpackage

// ===== hdl/sadc_tad_div.sv
`timescale 1ns/1ps
`default_nettype none
// Divider producing one-cycle bit period enables
module sadc_tad_div (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic restart,
	input wire logic [1:0] clkSel,
	output logic tadTick
);
	logic [7:0] cnt_q, cnt_d;
	logic tick_q, tick_d;
	logic [7:0] termCount;

	always_comb begin
		case (clkSel)
			sadc_pkg::SADC_DIV8: termCount = sadc_pkg::SADC_DIV8_TC;
			sadc_pkg::SADC_DIV16: termCount = sadc_pkg::SADC_DIV16_TC;
			sadc_pkg::SADC_DIV32: termCount = sadc_pkg::SADC_DIV32_TC;
			default: termCount = sadc_pkg::SADC_DIV128_TC;
		endcase
	end

	always_comb begin
		cnt_d = cnt_q + 8'h01;
		tick_d = 1'b0;
		if (restart) begin
			cnt_d = 8'h00;
		end else if (cnt_q >= termCount) begin
			cnt_d = 8'h00;
			tick_d = 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cnt_q <= 8'h00;
			tick_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			tick_q <= tick_d;
		end
	end

	assign tadTick = tick_q;
endmodule
`default_nettype wire

// ===== hdl/sadc_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
// What this block does
// - Produce a 12-bit successive approximation result into high and low registers
// - channel_select routes chosen analog input to sample-and-hold
// - Code 10010 selects the internal 1.2V reference
// - Conversion clock is system clock over 8, 16, 32 or 128
// - One bit per period; full conversion takes 49 periods
// - Done flag sets at every completion regardless of irq enable
// - Interrupt request when done flag and irq enable are both set
// - Align 0 stores left-aligned 12 bits, align 1 right-aligned 10 bits
// - Left form: bits 11..4 in high, bits 3..0 in low upper nibble
// - Right form: bits 11..10 in high low bits, 9..2 in low
// - Conversion starts only with converter on and a later go
// - Setting on and go together while off starts nothing
// - Go reads 1 while converting, cleared by hardware on completion
// - Completion clears go, sets flag and loads result together
// - Clearing go early aborts; result registers keep old contents
// - After abort resume sampling at once; wait 2 periods before next start
// - Reset disables converter and terminates any conversion
// - Converter does not operate in sleep mode
module sadc_ctrl (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic sleepMode,
	input wire logic ctrlWrite,
	input wire logic wrConverterOn,
	input wire logic wrConvertGo,
	input wire logic [4:0] wrChannelSelect,
	input wire logic [1:0] wrConvClockSelect,
	input wire logic wrResultAlign,
	input wire logic flagClear,
	input wire logic wrIrqEnable,
	input wire logic irqEnWrite,
	input wire logic cmpIn,
	output logic converterOn,
	output logic convertGo,
	output logic [4:0] channelSelect,
	output logic [1:0] convClockSelect,
	output logic resultAlign,
	output logic convDoneFlag,
	output logic convIrqEnable,
	output logic convIrq,
	output logic [7:0] resultHigh,
	output logic [7:0] resultLow,
	output logic sampleHold,
	output logic refSelect,
	output logic [4:0] pinSelect,
	output logic [11:0] dacTrial
);
	logic on_q, on_d, go_q, go_d, align_q, align_d, flag_q, flag_d;
	logic ie_q, ie_d, irq_q, irq_d, hold_q, hold_d, ref_q, ref_d;
	logic [4:0] ch_q, ch_d, pin_q, pin_d;
	logic [1:0] cks_q, cks_d, hcnt_q, hcnt_d;
	logic [7:0] rh_q, rh_d, rl_q, rl_d;
	logic [5:0] tcnt_q, tcnt_d;
	logic [11:0] sar_q, sar_d;
	logic [3:0] bit_q, bit_d;
	logic cmpS1_q, cmpS2_q;
	sadc_pkg::sadc_state_t st_q, st_d;
	logic tadTick, divRestart, startReq, doneEv;

	// Comparator decision synchroniser
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			cmpS1_q <= 1'b0;
			cmpS2_q <= 1'b0;
		end else begin
			cmpS1_q <= cmpIn;
			cmpS2_q <= cmpS1_q;
		end
	end

	// Start needs converter already on
	// Only from idle, so a write during holdoff cannot restart the divider
	assign startReq = ctrlWrite && wrConvertGo && on_q && wrConverterOn && !go_q &&
		!sleepMode && (st_q == sadc_pkg::SADC_IDLE);
	assign divRestart = startReq;

	sadc_tad_div u_div (
		.sys_clk(sys_clk),
		.rst(rst),
		.restart(divRestart),
		.clkSel(cks_q),
		.tadTick(tadTick)
	);

	// Control, sequencing and result next state
	always_comb begin
		on_d = on_q;
		go_d = go_q;
		ch_d = ch_q;
		cks_d = cks_q;
		align_d = align_q;
		ie_d = ie_q;
		st_d = st_q;
		tcnt_d = tcnt_q;
		hcnt_d = hcnt_q;
		sar_d = sar_q;
		bit_d = bit_q;
		rh_d = rh_q;
		rl_d = rl_q;
		hold_d = hold_q;
		doneEv = 1'b0;
		if (ctrlWrite) begin
			on_d = wrConverterOn;
			ch_d = wrChannelSelect;
			cks_d = wrConvClockSelect;
			align_d = wrResultAlign;
			if (!wrConvertGo) begin
				go_d = 1'b0;
			end
		end
		if (irqEnWrite) begin
			ie_d = wrIrqEnable;
		end
		case (st_q)
			sadc_pkg::SADC_IDLE: begin
				hold_d = 1'b0;
				if (startReq) begin
					go_d = 1'b1;
					st_d = sadc_pkg::SADC_CONV;
					tcnt_d = 6'h00;
					sar_d = 12'h800;
					bit_d = 4'hB;
				end
			end
			sadc_pkg::SADC_CONV: begin
				if (!go_d || !on_d || sleepMode) begin
					go_d = 1'b0;
					st_d = sadc_pkg::SADC_HOLDOFF;
					hcnt_d = 2'h0;
					hold_d = 1'b0;
				end else if (tadTick) begin
					tcnt_d = tcnt_q + 6'h01;
					hold_d = (tcnt_q >= sadc_pkg::SADC_FIRST_BIT_PERIOD - 6'h01);
					// One successive approximation decision per period
					if (tcnt_q >= sadc_pkg::SADC_FIRST_BIT_PERIOD &&
						tcnt_q < sadc_pkg::SADC_CONV_PERIODS) begin
						sar_d[bit_q] = cmpS2_q;
						if (bit_q != 4'h0) begin
							sar_d[bit_q - 4'h1] = 1'b1;
							bit_d = bit_q - 4'h1;
						end
					end
					if (tcnt_q == sadc_pkg::SADC_CONV_PERIODS - 6'h01) begin
						// Clear go, set flag, load result together
						go_d = 1'b0;
						doneEv = 1'b1;
						hold_d = 1'b0;
						st_d = sadc_pkg::SADC_IDLE;
						if (align_q) begin
							rh_d = {6'h00, sar_d[11:10]};
							rl_d = sar_d[9:2];
						end else begin
							rh_d = sar_d[11:4];
							rl_d = {sar_d[3:0], 4'h0};
						end
					end
				end
			end
			sadc_pkg::SADC_HOLDOFF: begin
				if (tadTick) begin
					hcnt_d = hcnt_q + 2'h1;
					if (hcnt_q == sadc_pkg::SADC_ABORT_PERIODS - 2'h1) begin
						st_d = sadc_pkg::SADC_IDLE;
					end
				end
			end
			default: st_d = sadc_pkg::SADC_IDLE;
		endcase
	end

	// Flag set by completion; set wins over clear
	assign flag_d = doneEv ? 1'b1 : (flagClear ? 1'b0 : flag_q);
	assign irq_d = flag_d && ie_d;
	assign ref_d = (ch_d == sadc_pkg::SADC_CH_REF12);
	assign pin_d = (ch_d <= sadc_pkg::SADC_CH_MAX_PIN) ? ch_d : 5'h00;

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			on_q <= 1'b0;
			go_q <= 1'b0;
			ch_q <= 5'h00;
			cks_q <= 2'h0;
			align_q <= 1'b0;
			ie_q <= 1'b0;
			flag_q <= 1'b0;
			irq_q <= 1'b0;
			st_q <= sadc_pkg::SADC_IDLE;
			tcnt_q <= 6'h00;
			hcnt_q <= 2'h0;
			sar_q <= 12'h000;
			bit_q <= 4'h0;
			rh_q <= sadc_pkg::SADC_RESULT_RST;
			rl_q <= sadc_pkg::SADC_RESULT_RST;
			hold_q <= 1'b0;
			ref_q <= 1'b0;
			pin_q <= 5'h00;
		end else begin
			on_q <= on_d;
			go_q <= go_d;
			ch_q <= ch_d;
			cks_q <= cks_d;
			align_q <= align_d;
			ie_q <= ie_d;
			flag_q <= flag_d;
			irq_q <= irq_d;
			st_q <= st_d;
			tcnt_q <= tcnt_d;
			hcnt_q <= hcnt_d;
			sar_q <= sar_d;
			bit_q <= bit_d;
			rh_q <= rh_d;
			rl_q <= rl_d;
			hold_q <= hold_d;
			ref_q <= ref_d;
			pin_q <= pin_d;
		end
	end

	// Outputs straight from flops
	assign converterOn = on_q;
	assign convertGo = go_q;
	assign channelSelect = ch_q;
	assign convClockSelect = cks_q;
	assign resultAlign = align_q;
	assign convDoneFlag = flag_q;
	assign convIrqEnable = ie_q;
	assign convIrq = irq_q;
	assign resultHigh = rh_q;
	assign resultLow = rl_q;
	assign sampleHold = hold_q;
	assign refSelect = ref_q;
	assign pinSelect = pin_q;
	assign dacTrial = sar_q;

	// Assertions
	// Combined enable and go never starts
	combined_no_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		(ctrlWrite && !on_q && wrConverterOn && wrConvertGo) |=> !go_q)
		else $error("start while converter was off");
	start_sets_go_a: assert property (@(posedge sys_clk) disable iff (rst)
		startReq && st_q == sadc_pkg::SADC_IDLE |=> go_q)
		else $error("go not set on start");
	done_sets_flag_a: assert property (@(posedge sys_clk) disable iff (rst)
		doneEv |=> flag_q && !go_q)
		else $error("completion not signalled");
	flag_sticky_a: assert property (@(posedge sys_clk) disable iff (rst)
		flag_q && !flagClear |=> flag_q)
		else $error("flag cleared by hardware");
	irq_gate_a: assert property (@(posedge sys_clk) disable iff (rst)
		##1 convIrq == ($past(flag_d) && $past(ie_d)))
		else $error("interrupt mismatch");
	abort_keeps_a: assert property (@(posedge sys_clk) disable iff (rst)
		st_q == sadc_pkg::SADC_HOLDOFF |-> $stable(rh_q) && $stable(rl_q))
		else $error("result changed after abort");
	right_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		doneEv && align_q |=> rh_q[7:2] == 6'h00)
		else $error("right aligned high bits nonzero");
	left_zero_a: assert property (@(posedge sys_clk) disable iff (rst)
		doneEv && !align_q |=> rl_q[3:0] == 4'h0)
		else $error("left aligned low nibble nonzero");
	sleep_idle_a: assert property (@(posedge sys_clk) disable iff (rst)
		sleepMode && go_q |=> !go_q)
		else $error("converting in sleep");
	go_busy_a: assert property (@(posedge sys_clk) disable iff (rst)
		convertGo == (st_q == sadc_pkg::SADC_CONV))
		else $error("go does not match busy state");
	holdoff_wait_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(st_q == sadc_pkg::SADC_HOLDOFF) |-> (st_q == sadc_pkg::SADC_HOLDOFF) [*8])
		else $error("holdoff ended early");
	holdoff_ends_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(st_q == sadc_pkg::SADC_HOLDOFF) |-> ##[1:260] st_q == sadc_pkg::SADC_IDLE)
		else $error("holdoff did not end");
	conv_done_c: cover property (@(posedge sys_clk) disable iff (rst) doneEv);
	abort_c: cover property (@(posedge sys_clk) disable iff (rst)
		st_q == sadc_pkg::SADC_HOLDOFF);
	irq_c: cover property (@(posedge sys_clk) disable iff (rst) convIrq);
endmodule
`default_nettype wire

// ===== sim/sadc_cmp_model.sv
`timescale 1ns/1ps
`default_nettype none
// Sample-hold and comparator stand-in for the analog side
module sadc_cmp_model #(
	parameter logic [11:0] REF_LEVEL = 12'h7A5
) (
	input wire logic sys_clk,
	input wire logic sampleHold,
	input wire logic refSelect,
	input wire logic [11:0] analogLevel,
	input wire logic [11:0] dacTrial,
	output logic cmpIn
);
	logic [11:0] held;
	logic keepBit;
	always_ff @(posedge sys_clk) begin
		if (!sampleHold) held <= refSelect ? REF_LEVEL : analogLevel;
	end
	// Keep trial bit; inverted while tracking so early samples show
	assign keepBit = (held >= dacTrial);
	assign cmpIn = sampleHold ? keepBit : !keepBit;
endmodule
`default_nettype wire

// ===== sim/test_sar_adc_conversion_control.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin checks++; if ((ex) !== (got)) begin failures++; \
	$display("MISMATCH %s exp %0h got %0h", nm, ex, got); end end
module test_sar_adc_conversion_control;
	localparam logic [11:0] REF = 12'h5D1;
	logic sys_clk = 0, rst = 1, sleepMode = 0, ctrlWrite = 0, wrConverterOn = 0;
	logic wrConvertGo = 0, wrResultAlign = 0, flagClear = 0, wrIrqEnable = 0, irqEnWrite = 0;
	logic [4:0] wrChannelSelect = 0, channelSelect, pinSelect;
	logic [1:0] wrConvClockSelect = 0, convClockSelect;
	logic [11:0] analogLevel = 0, dacTrial;
	logic cmpIn, converterOn, convertGo, resultAlign, convDoneFlag, convIrqEnable, convIrq;
	logic sampleHold, refSelect;
	logic [7:0] resultHigh, resultLow;
	int checks = 0, failures = 0, cyc = 0;
	logic [15:0] keep;
	sadc_ctrl sadc_ctrl_inst (.sys_clk(sys_clk), .rst(rst), .sleepMode(sleepMode),
		.ctrlWrite(ctrlWrite), .wrConverterOn(wrConverterOn), .wrConvertGo(wrConvertGo),
		.wrChannelSelect(wrChannelSelect), .wrConvClockSelect(wrConvClockSelect),
		.wrResultAlign(wrResultAlign), .flagClear(flagClear), .wrIrqEnable(wrIrqEnable),
		.irqEnWrite(irqEnWrite), .cmpIn(cmpIn), .converterOn(converterOn),
		.convertGo(convertGo), .channelSelect(channelSelect), .convClockSelect(convClockSelect),
		.resultAlign(resultAlign), .convDoneFlag(convDoneFlag), .convIrqEnable(convIrqEnable),
		.convIrq(convIrq), .resultHigh(resultHigh), .resultLow(resultLow),
		.sampleHold(sampleHold), .refSelect(refSelect), .pinSelect(pinSelect),
		.dacTrial(dacTrial));
	sadc_cmp_model #(.REF_LEVEL(REF)) sadc_cmp_model_inst (.sys_clk(sys_clk),
		.sampleHold(sampleHold), .refSelect(refSelect), .analogLevel(analogLevel),
		.dacTrial(dacTrial), .cmpIn(cmpIn));
	// Clock and hang guard
	always #4 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		cyc++;
		if (cyc == 40000) begin
			failures++;
			stop_test();
		end
	end
	// Expected register pair for an alignment
	function automatic logic [15:0] pack(input logic [11:0] r, input logic al);
		return al ? {6'h00, r[11:2]} : {r, 4'h0};
	endfunction
	// Control write of one cycle
	task automatic wr(input logic on, go, input logic [4:0] ch, input logic [1:0] cs,
		input logic al);
		@(posedge sys_clk);
		ctrlWrite <= 1'b1;
		wrConverterOn <= on;
		wrConvertGo <= go;
		wrChannelSelect <= ch;
		wrConvClockSelect <= cs;
		wrResultAlign <= al;
		@(posedge sys_clk);
		ctrlWrite <= 1'b0;
	endtask
	// Whole conversion, optionally aborted early
	task automatic conv(input logic [4:0] ch, input logic [1:0] cs, input logic al, ie, ab);
		int n, per;
		logic [11:0] lv;
		logic [15:0] old;
		per = (cs == 2'h3) ? 128 : 8 << cs;
		lv = 12'($urandom);
		old = {resultHigh, resultLow};
		@(posedge sys_clk);
		analogLevel <= lv;
		flagClear <= 1'b1;
		irqEnWrite <= 1'b1;
		wrIrqEnable <= ie;
		@(posedge sys_clk);
		flagClear <= 1'b0;
		irqEnWrite <= 1'b0;
		// Enable and channel first, go later
		wr(1'b1, 1'b0, ch, cs, al);
		repeat (4) @(posedge sys_clk);
		wr(1'b1, 1'b1, ch, cs, al);
		repeat (2) @(negedge sys_clk);
		`CHK("go", 1'b1, convertGo)
		`CHK("ref", ch == 5'h12, refSelect)
		`CHK("pin", (ch <= 5'h11) ? ch : 5'h00, pinSelect)
		`CHK("ch", ch, channelSelect)
		`CHK("al", al, resultAlign)
		`CHK("ie", ie, convIrqEnable)
		n = 0;
		while (convertGo === 1'b1 && n < 7000 && !(ab && n == 100)) begin
			@(negedge sys_clk);
			n++;
		end
		if (ab) begin
			wr(1'b1, 1'b0, ch, cs, al);
			repeat (3) @(negedge sys_clk);
			`CHK("go", 1'b0, convertGo)
			`CHK("res", old, {resultHigh, resultLow})
			`CHK("flag", 1'b0, convDoneFlag)
			repeat (2 * per + 4) @(posedge sys_clk);
		end else begin
			repeat (2) @(negedge sys_clk);
			`CHK("len", 1'b1, n >= 49 * per - 3 && n <= 49 * per + 3)
			`CHK("flag", 1'b1, convDoneFlag)
			`CHK("irq", ie, convIrq)
			`CHK("res", pack((ch == 5'h12) ? REF : lv, al), {resultHigh, resultLow})
		end
	endtask
	// Verdict and end of run
	task automatic stop_test();
		$display("checks %0d failures %0d", checks, failures);
		if (failures == 0 && checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	// Main sequence
	initial begin
		void'($urandom(32'h5D40));
		repeat (6) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		`CHK("on", 1'b0, converterOn)
		`CHK("res", 16'h0000, {resultHigh, resultLow})
		wr(1'b1, 1'b1, 5'h01, 2'h0, 1'b0);
		repeat (3) @(negedge sys_clk);
		`CHK("go", 1'b0, convertGo)
		// Reference never switched, no settle wait
		for (int cs = 0; cs < 4; cs++) begin
			conv(5'($urandom_range(17)), 2'(cs), 1'($urandom), 1'($urandom), 1'b0);
			`CHK("clk", 2'(cs), convClockSelect)
		end
		conv(5'h12, 2'h0, 1'b0, 1'b1, 1'b0);
		conv(5'h12, 2'h0, 1'b1, 1'b0, 1'b0);
		conv(5'h11, 2'h1, 1'b1, 1'b1, 1'b1);
		conv(5'h03, 2'h0, 1'b0, 1'b1, 1'b0);
		@(posedge sys_clk);
		sleepMode <= 1'b1;
		wr(1'b1, 1'b1, 5'h02, 2'h0, 1'b0);
		repeat (3) @(negedge sys_clk);
		`CHK("go", 1'b0, convertGo)
		@(posedge sys_clk);
		sleepMode <= 1'b0;
		keep = {resultHigh, resultLow};
		wr(1'b1, 1'b1, 5'h02, 2'h0, 1'b0);
		repeat (20) @(posedge sys_clk);
		sleepMode <= 1'b1;
		repeat (3) @(negedge sys_clk);
		`CHK("sleepgo", 1'b0, convertGo)
		`CHK("sleepres", keep, {resultHigh, resultLow})
		@(posedge sys_clk);
		sleepMode <= 1'b0;
		repeat (24) @(posedge sys_clk);
		wr(1'b1, 1'b1, 5'h02, 2'h0, 1'b0);
		repeat (50) @(posedge sys_clk);
		rst <= 1'b1;
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		@(negedge sys_clk);
		`CHK("go", 1'b0, convertGo)
		`CHK("on", 1'b0, converterOn)
		stop_test();
	end
endmodule
`default_nettype wire
